// ### hdl/ssp_defines.svh
// constants of the self sector programming controller
// assumes: included by its bare name from the modules and the testbench
`ifndef SSP_DEFINES_SVH
`define SSP_DEFINES_SVH

// ************************************************************
// register indexes (byte address is four times the index)
// ************************************************************
`define SSP_IDX_STATUS 8'hf0
`define SSP_IDX_OPTYPE 8'hf2
`define SSP_IDX_TWO 8'hf3
`define SSP_IDX_THREE 8'hf4
`define SSP_IDX_FOUR 8'hf5
`define SSP_IDX_FIVE 8'hf6
`define SSP_IDX_SECT 8'hf7
`define SSP_IDX_LOW 8'hfb
`define SSP_IDX_DATA 8'hfc

// ************************************************************
// codes, keys, fields and reset values
// ************************************************************
`define SSP_OP_ERASE 8'he6
`define SSP_OP_PROG 8'h6e
`define SSP_KEY_TWO 4'h5
`define SSP_KEY_THREE 4'ha
`define SSP_KEY_FOUR 4'h9
`define SSP_KEY_FIVE 4'h6
`define SSP_LAST_SECTOR 6'h0f
`define SSP_RST_BYTE 8'h00
`define SSP_RST_KEY 4'h0
`define SSP_LAST_STEP 3'h4
`define SSP_ST_BUSY 0
`define SSP_ST_ABORT 1
`define SSP_ST_DONE 2

`endif

// ### hdl/ssp_pkg.sv
// types shared by the self sector programming controller
// assumes: nothing beyond a systemverilog compiler
package ssp_pkg;
  typedef enum logic [1:0] {
    SSP_IDLE = 2'b00,
    SSP_ERASE = 2'b01,
    SSP_PROG = 2'b10
  } ssp_state_e;
  typedef logic [7:0] ssp_byte_t;
  typedef logic [2:0] ssp_step_t;
endpackage

// ### hdl/ssp_unlock_seq.sv
// tracks the ordered unlock writes and flags start or abort
// assumes: one write strobe per accepted bus write, pclk domain
`timescale 1ns/10ps
`include "ssp_defines.svh"
module ssp_unlock_seq (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // accepted register write
  input wire logic wr_en,
  input wire ssp_pkg::ssp_byte_t wr_idx,
  input wire ssp_pkg::ssp_byte_t wr_data,
  // sequence result
  output ssp_pkg::ssp_step_t step,
  output logic trigger,
  output logic abort
);
  import ssp_pkg::*;

  ssp_step_t step_q, step_d;
  logic trig_q, trig_d, abort_q, abort_d;

  function automatic logic key_ok(ssp_step_t s, ssp_byte_t i, ssp_byte_t d);
    logic ok;
    ok = 1'b0;
    case (s)
      3'h0: ok = (i == `SSP_IDX_OPTYPE) &&
                 (d == `SSP_OP_ERASE || d == `SSP_OP_PROG);
      3'h1: ok = (i == `SSP_IDX_TWO) && (d[3:0] == `SSP_KEY_TWO);
      3'h2: ok = (i == `SSP_IDX_THREE) && (d[3:0] == `SSP_KEY_THREE);
      3'h3: ok = (i == `SSP_IDX_FOUR) && (d[3:0] == `SSP_KEY_FOUR);
      3'h4: ok = (i == `SSP_IDX_FIVE) && (d[3:0] == `SSP_KEY_FIVE);
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  function automatic logic is_key_reg(ssp_byte_t i);
    return (i >= `SSP_IDX_OPTYPE) && (i <= `SSP_IDX_FIVE);
  endfunction

  // any stray write mid-sequence breaks it, so a half-done unlock
  // cannot be finished by unrelated code later
  always_comb begin
    step_d = step_q;
    trig_d = 1'b0;
    abort_d = 1'b0;
    if (wr_en) begin
      if (key_ok(step_q, wr_idx, wr_data)) begin
        if (step_q == `SSP_LAST_STEP) begin
          step_d = 3'h0;
          trig_d = 1'b1;
        end else begin
          step_d = step_q + 3'h1;
        end
      end else if (step_q != 3'h0 || is_key_reg(wr_idx)) begin
        step_d = 3'h0;
        abort_d = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_q <= 3'h0;
      trig_q <= 1'b0;
      abort_q <= 1'b0;
    end else begin
      step_q <= step_d;
      trig_q <= trig_d;
      abort_q <= abort_d;
    end
  end

  assign step = step_q;
  assign trigger = trig_q;
  assign abort = abort_q;
endmodule

// ### hdl/ssp_flash_ctrl.sv
// self sector programming controller: apb registers, unlock check,
// and the erase or program request toward the flash array
// assumes: flash array pulses flash_done once per request; the cpu
// stalls while cpu_idle is high
`timescale 1ns/10ps
`include "ssp_defines.svh"
module ssp_flash_ctrl (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // flash array
  input wire logic flash_done,
  output logic [15:0] flash_addr,
  output logic [7:0] flash_wdata,
  output logic flash_erase,
  output logic flash_prog,
  // cpu
  output logic cpu_idle
);
  import ssp_pkg::*;

  // ************************************************************
  // bus decode
  // ************************************************************
  ssp_byte_t idx;
  logic hit, access, wr_en;
  logic pready_q, pready_d, pslverr_q, pslverr_d;
  logic [31:0] prdata_q, prdata_d;

  function automatic logic mapped(ssp_byte_t i);
    return (i == `SSP_IDX_STATUS) || ((i >= `SSP_IDX_OPTYPE) &&
           (i <= `SSP_IDX_SECT)) || (i == `SSP_IDX_LOW) ||
           (i == `SSP_IDX_DATA);
  endfunction

  assign idx = paddr[9:2];
  assign hit = mapped(idx) && (paddr[11:10] == 2'h0) &&
               (paddr[1:0] == 2'h0);
  assign access = psel && penable;

  // ************************************************************
  // register and operation state
  // ************************************************************
  ssp_byte_t optype_q, optype_d, sect_q, sect_d, low_q, low_d;
  ssp_byte_t data_q, data_d;
  logic [3:0] two_q, two_d, three_q, three_d;
  logic [3:0] four_q, four_d, five_q, five_d;
  logic abort_flag_q, abort_flag_d, done_flag_q, done_flag_d;
  ssp_state_e state_q, state_d;
  logic [15:0] faddr_q, faddr_d;
  ssp_byte_t fdata_q, fdata_d;
  logic idle_q, idle_d;
  logic erase_q, erase_d, prog_q, prog_d;
  ssp_step_t seq_step;
  logic seq_trig, seq_abort, start_ok, reject, busy;

  assign busy = (state_q != SSP_IDLE);
  // writes are refused while an operation runs; the cpu is idle then
  assign wr_en = access && pready_q && pwrite && hit && !busy;

  ssp_unlock_seq u_seq (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(wr_en),
    .wr_idx(idx),
    .wr_data(pwdata[7:0]),
    .step(seq_step),
    .trigger(seq_trig),
    .abort(seq_abort)
  );

  // last sector holds the boot code, so erasing it is rejected
  assign reject = seq_trig && (optype_q == `SSP_OP_ERASE) &&
                  (sect_q[7:2] == `SSP_LAST_SECTOR);
  assign start_ok = seq_trig && !reject;

  // ************************************************************
  // bus answer: one wait cycle, then registered data
  // ************************************************************
  always_comb begin
    pready_d = 1'b0;
    pslverr_d = 1'b0;
    prdata_d = prdata_q;
    if (access && !pready_q) begin
      pready_d = 1'b1;
      pslverr_d = !hit;
      if (!pwrite) begin
        prdata_d = 32'h0;
        case (idx)
          `SSP_IDX_STATUS: prdata_d[5:0] = {seq_step, done_flag_q,
                                            abort_flag_q, busy};
          `SSP_IDX_OPTYPE: prdata_d[7:0] = optype_q;
          `SSP_IDX_TWO: prdata_d[3:0] = two_q;
          `SSP_IDX_THREE: prdata_d[3:0] = three_q;
          `SSP_IDX_FOUR: prdata_d[3:0] = four_q;
          `SSP_IDX_FIVE: prdata_d[3:0] = five_q;
          `SSP_IDX_SECT: prdata_d[7:0] = sect_q;
          `SSP_IDX_LOW: prdata_d[7:0] = low_q;
          `SSP_IDX_DATA: prdata_d[7:0] = data_q;
          default: prdata_d = 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
    end
  end

  // ************************************************************
  // register file
  // ************************************************************
  always_comb begin
    optype_d = optype_q;
    two_d = two_q;
    three_d = three_q;
    four_d = four_q;
    five_d = five_q;
    sect_d = sect_q;
    low_d = low_q;
    data_d = data_q;
    abort_flag_d = abort_flag_q;
    done_flag_d = done_flag_q;
    if (wr_en) begin
      case (idx)
        `SSP_IDX_STATUS: begin
          if (pwdata[`SSP_ST_ABORT]) abort_flag_d = 1'b0;
          if (pwdata[`SSP_ST_DONE]) done_flag_d = 1'b0;
        end
        `SSP_IDX_OPTYPE: optype_d = pwdata[7:0];
        `SSP_IDX_TWO: two_d = pwdata[3:0];
        `SSP_IDX_THREE: three_d = pwdata[3:0];
        `SSP_IDX_FOUR: four_d = pwdata[3:0];
        `SSP_IDX_FIVE: five_d = pwdata[3:0];
        `SSP_IDX_SECT: sect_d = pwdata[7:0];
        `SSP_IDX_LOW: low_d = pwdata[7:0];
        `SSP_IDX_DATA: data_d = pwdata[7:0];
        default: optype_d = optype_q;
      endcase
    end
    // keys are consumed, so every further operation needs a fresh unlock
    if (seq_trig || seq_abort) begin
      optype_d = `SSP_RST_BYTE;
      two_d = `SSP_RST_KEY;
      three_d = `SSP_RST_KEY;
      four_d = `SSP_RST_KEY;
      five_d = `SSP_RST_KEY;
    end
    // set after clear, so a flag raised in the clearing cycle survives
    if (seq_abort || reject) abort_flag_d = 1'b1;
    if (busy && flash_done) done_flag_d = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      optype_q <= `SSP_RST_BYTE;
      two_q <= `SSP_RST_KEY;
      three_q <= `SSP_RST_KEY;
      four_q <= `SSP_RST_KEY;
      five_q <= `SSP_RST_KEY;
      sect_q <= `SSP_RST_BYTE;
      low_q <= `SSP_RST_BYTE;
      data_q <= `SSP_RST_BYTE;
      abort_flag_q <= 1'b0;
      done_flag_q <= 1'b0;
    end else begin
      optype_q <= optype_d;
      two_q <= two_d;
      three_q <= three_d;
      four_q <= four_d;
      five_q <= five_d;
      sect_q <= sect_d;
      low_q <= low_d;
      data_q <= data_d;
      abort_flag_q <= abort_flag_d;
      done_flag_q <= done_flag_d;
    end
  end

  // ************************************************************
  // flash operation
  // ************************************************************
  always_comb begin
    state_d = state_q;
    faddr_d = faddr_q;
    fdata_d = fdata_q;
    idle_d = idle_q;
    case (state_q)
      SSP_IDLE: begin
        if (start_ok) begin
          idle_d = 1'b1;
          if (optype_q == `SSP_OP_ERASE) begin
            state_d = SSP_ERASE;
            faddr_d = {sect_q[7:2], 10'h000};
          end else begin
            state_d = SSP_PROG;
            faddr_d = {sect_q, low_q};
            fdata_d = data_q;
          end
        end
      end
      SSP_ERASE, SSP_PROG: begin
        if (flash_done) begin
          state_d = SSP_IDLE;
          idle_d = 1'b0;
        end
      end
      default: begin
        state_d = SSP_IDLE;
        idle_d = 1'b0;
      end
    endcase
    // strobes leave from flops, so the array sees no decode glitches
    erase_d = (state_d == SSP_ERASE);
    prog_d = (state_d == SSP_PROG);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= SSP_IDLE;
      faddr_q <= 16'h0000;
      fdata_q <= 8'h00;
      idle_q <= 1'b0;
      erase_q <= 1'b0;
      prog_q <= 1'b0;
    end else begin
      state_q <= state_d;
      faddr_q <= faddr_d;
      fdata_q <= fdata_d;
      idle_q <= idle_d;
      erase_q <= erase_d;
      prog_q <= prog_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign flash_addr = faddr_q;
  assign flash_wdata = fdata_q;
  assign flash_erase = erase_q;
  assign flash_prog = prog_q;
  assign cpu_idle = idle_q;

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_wr(ssp_byte_t i);
    wr_en && idx == i;
  endsequence
  sequence s_aborted;
    seq_abort ##1 abort_flag_q && !busy;
  endsequence

  property p_two_bad;
    s_wr(`SSP_IDX_TWO) and pwdata[3:0] != `SSP_KEY_TWO |=> s_aborted;
  endproperty
  a_two_bad: assert property (p_two_bad) else $error("step two");
  property p_three_bad;
    s_wr(`SSP_IDX_THREE) and pwdata[3:0] != `SSP_KEY_THREE |=> s_aborted;
  endproperty
  a_three_bad: assert property (p_three_bad) else $error("step three");
  property p_four_bad;
    s_wr(`SSP_IDX_FOUR) and pwdata[3:0] != `SSP_KEY_FOUR |=> s_aborted;
  endproperty
  a_four_bad: assert property (p_four_bad) else $error("step four");
  property p_five_bad;
    s_wr(`SSP_IDX_FIVE) and pwdata[3:0] != `SSP_KEY_FIVE
      |=> !seq_trig ##1 !busy;
  endproperty
  a_five_bad: assert property (p_five_bad) else $error("step five");
  property p_key_read;
    pready_q && !pslverr_q && $past(idx) == `SSP_IDX_THREE && $past(!pwrite)
      |-> prdata_q[31:4] == 28'h0;
  endproperty
  a_key_read: assert property (p_key_read) else $error("upper bits");
  property p_idle_prog;
    flash_prog && flash_done |=> !flash_prog && !cpu_idle;
  endproperty
  a_idle_prog: assert property (p_idle_prog) else $error("prog end");
  property p_idle_hold;
    busy |-> cpu_idle;
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("cpu awake");
  property p_erase_sect;
    $rose(flash_erase) |-> faddr_q == {sect_q[7:2], 10'h000} &&
      $past(optype_q) == `SSP_OP_ERASE;
  endproperty
  a_erase_sect: assert property (p_erase_sect) else $error("erase");
  property p_prog_addr;
    $rose(flash_prog) |-> faddr_q == {sect_q, low_q} && fdata_q == data_q
      && $past(optype_q) == `SSP_OP_PROG;
  endproperty
  a_prog_addr: assert property (p_prog_addr) else $error("prog");
  property p_no_last;
    flash_erase |-> faddr_q[15:10] != `SSP_LAST_SECTOR;
  endproperty
  a_no_last: assert property (p_no_last) else $error("last erase");
  property p_start_cause;
    $rose(busy) |-> $past(seq_trig) && $past(seq_step, 2) == `SSP_LAST_STEP;
  endproperty
  a_start_cause: assert property (p_start_cause) else $error("start");
endmodule

// ### testbench/ssp_flash_ctrl_test.sv
// self-checking bench for the self sector programming controller
// assumes: design files under hdl/, apb slave answering after wait states
`timescale 1ns/10ps
`include "ssp_defines.svh"
module ssp_flash_ctrl_test;
  import ssp_pkg::*;
  // ************************************************************
  // signals
  // ************************************************************
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic flash_done;
  logic [15:0] flash_addr;
  logic [7:0] flash_wdata;
  logic flash_erase;
  logic flash_prog;
  logic cpu_idle;
  int mismatches;
  int checked;
  logic [31:0] rd_q;
  logic err_q;
  logic [7:0] map_q [9];

  ssp_flash_ctrl dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .flash_done(flash_done),
    .flash_addr(flash_addr), .flash_wdata(flash_wdata),
    .flash_erase(flash_erase), .flash_prog(flash_prog),
    .cpu_idle(cpu_idle)
  );

  initial pclk = 1'b0;
  always #2.5 pclk = ~pclk;

  // ************************************************************
  // tasks
  // ************************************************************
  task automatic check(input string name, input logic [31:0] seen,
      input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // request held until pready is sampled high; no latency assumed
  task automatic apb(input logic wr, input logic [7:0] idx,
      input logic [31:0] data);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= data;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) check("pready", {31'h0, pready}, 32'h1);
  endtask

  // keys are written with junk in the upper bits, which must be ignored
  task automatic run_op(input logic [7:0] op, input logic [15:0] keys,
      input logic ok, input logic intrude, input logic [15:0] addr,
      input logic [7:0] wdata);
    logic early;
    // a bad op code or step-two key aborts at once and consumes the keys
    early = (op == `SSP_OP_ERASE || op == `SSP_OP_PROG) &&
      (keys[15:12] == `SSP_KEY_TWO);
    apb(1'b1, `SSP_IDX_OPTYPE, {24'h0, op});
    apb(1'b1, `SSP_IDX_TWO, {28'hfffffff, keys[15:12]});
    apb(1'b0, `SSP_IDX_TWO, 32'h0);
    check("key_read", rd_q,
      early ? {28'h0, keys[15:12]} : 32'h0);
    apb(1'b0, `SSP_IDX_STATUS, 32'h0);
    check("step", rd_q, early ? 32'h10 : 32'h2);
    if (intrude) apb(1'b1, `SSP_IDX_DATA, 32'h11);
    apb(1'b1, `SSP_IDX_THREE, {28'hfffffff, keys[11:8]});
    apb(1'b1, `SSP_IDX_FOUR, {28'hfffffff, keys[7:4]});
    apb(1'b1, `SSP_IDX_FIVE, {28'hfffffff, keys[3:0]});
    repeat (4) @(posedge pclk);
    #1;
    check("erase", {31'h0, flash_erase},
      {31'h0, ok && (op == `SSP_OP_ERASE)});
    check("prog", {31'h0, flash_prog},
      {31'h0, ok && (op == `SSP_OP_PROG)});
    check("idle", {31'h0, cpu_idle}, {31'h0, ok});
    if (ok) begin
      check("addr", {16'h0, flash_addr}, {16'h0, addr});
      if (op == `SSP_OP_PROG) check("wdata", {24'h0, flash_wdata},
        {24'h0, wdata});
      apb(1'b1, `SSP_IDX_SECT, 32'hff);
      #1;
      check("busy_addr", {16'h0, flash_addr}, {16'h0, addr});
      check("busy_idle", {31'h0, cpu_idle}, 32'h1);
      apb(1'b0, `SSP_IDX_STATUS, 32'h0);
      check("busy_status", rd_q, 32'h1);
      @(posedge pclk);
      flash_done <= 1'b1;
      @(posedge pclk);
      flash_done <= 1'b0;
      @(posedge pclk);
      #1;
      check("idle_end", {31'h0, cpu_idle}, 32'h0);
    end
    apb(1'b0, `SSP_IDX_STATUS, 32'h0);
    check("status", rd_q, ok ? 32'h4 : 32'h2);
    apb(1'b1, `SSP_IDX_STATUS, 32'h6);
    apb(1'b0, `SSP_IDX_FIVE, 32'h0);
    check("key_used", rd_q, 32'h0);
  endtask

  // ************************************************************
  // tests
  // ************************************************************
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    flash_done = 1'b0;
    mismatches = 0;
    checked = 0;
    map_q = '{8'hf0, 8'hf2, 8'hf3, 8'hf4, 8'hf5, 8'hf6, 8'hf7, 8'hfb,
      8'hfc};
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    foreach (map_q[i]) begin
      apb(1'b0, map_q[i], 32'h0);
      check("reset_val", rd_q, 32'h0);
    end
    apb(1'b1, `SSP_IDX_SECT, 32'h00);
    apb(1'b1, `SSP_IDX_SECT, 32'h09);
    apb(1'b1, `SSP_IDX_LOW, 32'h34);
    apb(1'b1, `SSP_IDX_DATA, 32'ha5);
    run_op(`SSP_OP_PROG, 16'h5a96, 1'b1, 1'b0, 16'h0934, 8'ha5);
    apb(1'b1, `SSP_IDX_DATA, 32'h3c);
    run_op(`SSP_OP_PROG, 16'h5a96, 1'b1, 1'b0, 16'h0934, 8'h3c);
    apb(1'b1, `SSP_IDX_SECT, 32'h0e);
    run_op(`SSP_OP_ERASE, 16'h5a96, 1'b1, 1'b0, 16'h0c00, 8'h0);
    run_op(`SSP_OP_ERASE, 16'h5a96, 1'b1, 1'b0, 16'h0c00, 8'h0);
    for (int i = 0; i < 4; i++) begin
      run_op(`SSP_OP_ERASE, 16'h5a96 ^ (16'h1 << (4 * i)), 1'b0, 1'b0,
        16'h0, 8'h0);
    end
    apb(1'b1, `SSP_IDX_SECT, 32'h3c);
    run_op(`SSP_OP_ERASE, 16'h5a96, 1'b0, 1'b0, 16'h0, 8'h0);
    apb(1'b1, `SSP_IDX_SECT, 32'h0c);
    run_op(8'h55, 16'h5a96, 1'b0, 1'b0, 16'h0, 8'h0);
    run_op(`SSP_OP_PROG, 16'h5a96, 1'b0, 1'b1, 16'h0, 8'h0);
    apb(1'b0, 8'h10, 32'h0);
    check("unmapped_err", {31'h0, err_q}, 32'h1);
    check("unmapped_data", rd_q, 32'h0);
    apb(1'b1, `SSP_IDX_SECT, 32'h00);
    apb(1'b0, `SSP_IDX_SECT, 32'h0);
    check("sect_clear", rd_q, 32'h0);
    finish_test;
  end

  // whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge pclk);
    mismatches++;
    finish_test;
  end
endmodule
